/* shared/ips_pkg.sv */
// Package for the interrupt priority and status block.
// Assumes one 25 MHz clock domain and an AHB-Lite master.
package ips_pkg;

  // Source indices, highest priority first (reset and trap handled apart)
  localparam int SRC_EXT  = 0;
  localparam int SRC_CH0  = 1;
  localparam int SRC_CH1  = 2;
  localparam int SRC_OVF  = 3;
  localparam int SRC_TEST = 4;
  localparam int SRC_KEY  = 5;
  localparam int SRC_CONV = 6;
  localparam int NUM_SRC  = 7;

  // Vector pairs, high byte at the lower address
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] VEC_EXT   = 16'hFFFA;
  localparam logic [15:0] VEC_CH0   = 16'hFFF6;
  localparam logic [15:0] VEC_CH1   = 16'hFFF4;
  localparam logic [15:0] VEC_OVF   = 16'hFFF2;
  localparam logic [15:0] VEC_TEST  = 16'hFFEC;
  localparam logic [15:0] VEC_KEY   = 16'hFFE0;
  localparam logic [15:0] VEC_CONV  = 16'hFFDE;
  // Fixed contents of the test pair
  localparam logic [7:0]  TEST_VEC_HI = 8'h00;
  localparam logic [7:0]  TEST_VEC_LO = 8'h83;

  // Interrupt mask position in the condition code register
  localparam int CCR_I_BIT = 3;

  // Stack frame length and fetch lengths in bytes
  localparam logic [2:0] FRAME_LEN = 3'h5;
  localparam logic [2:0] VEC_LEN   = 3'h2;

  // Register byte offsets and reset values
  localparam logic [7:0] OFS_PEND_LOW = 8'h00;
  localparam logic [7:0] OFS_PEND_MID = 8'h04;
  localparam logic [7:0] OFS_EVT_STS  = 8'h08;
  localparam logic [7:0] OFS_EVT_MASK = 8'h0C;
  localparam logic [7:0] RST_PEND     = 8'h00;
  localparam logic [2:0] RST_EVT      = 3'h0;

  // Event bits of status and mask
  localparam int EVT_HW  = 0;
  localparam int EVT_SWI = 1;
  localparam int EVT_RTI = 2;

  // Processor context exchanged with the core
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  condition_code_register;
    logic [7:0]  acc;
    logic [7:0]  idxLo;
  } ips_ctx_t;

  // Memory request toward the system bus
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } ips_mem_t;

endpackage

/* hdl/ips_interrupt_priority_status.sv */
// Interrupt arbitration, stacking and pending-status registers.
// Assumes peripherals and core share clk; memory answers a read
// with data on memRdata one cycle after the request.
//
// Functional notes
// R01 - Trap instruction enters even when masked
// R02 - Trap stacks PC, hardware stacks PC-1
// R03 - Global mask blocks all but trap
// R04 - Fixed priority order, timer channel vectors
// R05 - Reset, trap, pin vectors, high first
// R06 - Overflow, keypad, converter vector pairs
// R07 - Each source sets its own flag
// R08 - Flag reads one while request pending
// R09 - Low register layout, bits 0,1,3 zero
// R10 - Mid register holds flags 14..7; the code places flags 15..8 there (TEST at bit 1, KEY at bit 7)
// R11 - Test pair has fixed contents
// R12 - Highest first; pending taken after return
// R13 - High index register is never stacked
// R14 - Status registers read-only, reset zero
// R15 - Return pulls CONDITION_CODE_REGISTER, A, X, PCL, PCH
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module ips_interrupt_priority_status #(
  parameter int NUM_SRC = 7
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Peripheral flags and their local enables
  input  wire logic [NUM_SRC-1:0]    srcFlag,
  input  wire logic [NUM_SRC-1:0]    srcEn,
  // Core handshake
  input  wire logic                  instrEnd,
  input  wire logic                  trapExec,
  input  wire logic                  rtiExec,
  input  wire ips_pkg::ips_ctx_t     ctxIn,
  output ips_pkg::ips_ctx_t          ctxOut,
  output logic                       ctxLoad,
  output logic                       busy,
  output logic [7:0]                 opcodeOut,
  output logic [7:0]                 operandOut,
  output logic                       fetchDone,
  // Memory port
  output ips_pkg::ips_mem_t          memReq,
  input  wire logic [7:0]            memRdata,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  output logic                       irq
);

  // Refuse a source count the priority table cannot serve
  if (NUM_SRC != ips_pkg::NUM_SRC)
  begin : g_chk
    $error("NUM_SRC must match the source table");
  end

  // One-hot sequencer states
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_PUSH  = 5'b00010,
    S_VECT  = 5'b00100,
    S_PULL  = 5'b01000,
    S_FETCH = 5'b10000
  } ips_state_t;

  // Reset release
  logic                  rstMeta;        // First synchroniser stage
  logic                  rstSyncN;       // Released reset copy
  // Sequencer
  ips_state_t            state_reg;      // Current phase
  logic [2:0]            step_reg;       // Byte counter in a phase
  logic [15:0]           vec_reg;        // Selected vector pair
  logic                  testVec_reg;    // Test pair chosen
  logic [15:0]           pcNew_reg;      // Vector being assembled
  ips_pkg::ips_ctx_t     ctx_reg;        // Working context
  // Status
  logic [NUM_SRC-1:0]    pend;           // Live pending requests
  logic [7:0]            pendLow_reg;    // Low pending register
  logic [7:0]            pendMid_reg;    // Mid pending register
  logic [2:0]            evtSts_reg;     // Sticky events
  logic [2:0]            evtMask_reg;    // Event mask
  logic [2:0]            evtSet;         // Event pulses
  // Bus
  logic                  dpWr_reg;       // Write in data phase
  logic [7:0]            dpAddr_reg;     // Its address
  logic                  hwReq;          // Unmasked hardware request
  logic [2:0]            win;            // Winning source index

  assign ctxOut = ctx_reg;

  // Highest priority pending source: lowest index wins
  function automatic logic [2:0] pickSrc(input logic [NUM_SRC-1:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (p[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Vector pair of a maskable source
  function automatic logic [15:0] vecOf(input logic [2:0] s);
    logic [15:0] v;
    v = ips_pkg::VEC_CONV;
    case (s)
      3'h0: v = ips_pkg::VEC_EXT;   // [R05]
      3'h1: v = ips_pkg::VEC_CH0;   // [R04]
      3'h2: v = ips_pkg::VEC_CH1;   // [R04]
      3'h3: v = ips_pkg::VEC_OVF;   // [R06]
      3'h4: v = ips_pkg::VEC_TEST;
      3'h5: v = ips_pkg::VEC_KEY;   // [R06]
      default: v = ips_pkg::VEC_CONV; // [R06]
    endcase
    return v;
  endfunction

  // Register read decode
  function automatic logic [31:0] rdMux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      ips_pkg::OFS_PEND_LOW: d = {24'h000000, pendLow_reg};
      ips_pkg::OFS_PEND_MID: d = {24'h000000, pendMid_reg};
      ips_pkg::OFS_EVT_STS:  d = {29'h0000_0000, evtSts_reg};
      ips_pkg::OFS_EVT_MASK: d = {29'h0000_0000, evtMask_reg};
      default:               d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Reset is taken at once and released through two flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // A request counts when its flag and its local enable are both set
  assign pend  = srcFlag & srcEn;                        // [R07] [R08]
  assign win   = pickSrc(pend);                          // [R04] [R12]
  // Global mask holds off every hardware source
  assign hwReq = (|pend) && !ctxIn.condition_code_register[ips_pkg::CCR_I_BIT]; // [R03]

  // Pending registers mirror requests; flags without a source read 0
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      pendLow_reg <= ips_pkg::RST_PEND;                  // [R14]
      pendMid_reg <= ips_pkg::RST_PEND;                  // [R14]
    end
    else
    begin
      pendLow_reg <= {1'b0, pend[ips_pkg::SRC_OVF],
                      pend[ips_pkg::SRC_CH1], pend[ips_pkg::SRC_CH0],
                      1'b0, pend[ips_pkg::SRC_EXT], 2'b00}; // [R09]
      pendMid_reg <= {pend[ips_pkg::SRC_KEY], 5'h00,
                      pend[ips_pkg::SRC_TEST], 1'b0};    // [R10]
    end
  end

  // Sequencer: entry stacking, vector fetch, return and refetch.
  // The high index register is not part of the frame at all. [R13]
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      // Leaving reset fetches the reset vector first
      state_reg   <= S_VECT;                             // [R05]
      step_reg    <= 3'h0;
      vec_reg     <= ips_pkg::VEC_RESET;
      testVec_reg <= 1'b0;
      pcNew_reg   <= 16'h0000;
      ctx_reg     <= '0;
      ctxLoad     <= 1'b0;
      busy        <= 1'b1;
      memReq      <= '0;
      opcodeOut   <= 8'h00;
      operandOut  <= 8'h00;
      fetchDone   <= 1'b0;
      evtSet      <= 3'h0;
    end
    else
    begin
      ctxLoad   <= 1'b0;
      fetchDone <= 1'b0;
      evtSet    <= 3'h0;
      memReq    <= '0;
      case (state_reg)
        S_IDLE:
        begin
          busy <= 1'b0;
          if (instrEnd && trapExec)
          begin
            // Trap ignores the mask and stacks PC itself
            ctx_reg     <= ctxIn;                        // [R01] [R02]
            vec_reg     <= ips_pkg::VEC_TRAP;
            testVec_reg <= 1'b0;
            evtSet[ips_pkg::EVT_SWI] <= 1'b1;
            state_reg   <= S_PUSH;
            step_reg    <= 3'h0;
            busy        <= 1'b1;
          end
          else if (instrEnd && rtiExec)
          begin
            ctx_reg   <= ctxIn;
            state_reg <= S_PULL;
            step_reg  <= 3'h0;
            busy      <= 1'b1;
          end
          else if (instrEnd && hwReq)
          begin
            // Hardware entry stacks the address one below PC
            ctx_reg     <= ctxIn;
            ctx_reg.pc  <= ctxIn.pc - 16'h0001;          // [R02]
            vec_reg     <= vecOf(win);                   // [R04]
            testVec_reg <= (win == 3'(ips_pkg::SRC_TEST));
            evtSet[ips_pkg::EVT_HW] <= 1'b1;
            state_reg   <= S_PUSH;
            step_reg    <= 3'h0;
            busy        <= 1'b1;
          end
        end
        S_PUSH:
        begin
          // Frame from SP downward: PCH, PCL, X, A, CONDITION_CODE_REGISTER
          memReq.we   <= 1'b1;
          memReq.addr <= ctx_reg.sp - 16'(step_reg);
          case (step_reg)
            3'h0:    memReq.wdata <= ctx_reg.pc[15:8];
            3'h1:    memReq.wdata <= ctx_reg.pc[7:0];
            3'h2:    memReq.wdata <= ctx_reg.idxLo;
            3'h3:    memReq.wdata <= ctx_reg.acc;
            default: memReq.wdata <= ctx_reg.condition_code_register;
          endcase
          if (step_reg == ips_pkg::FRAME_LEN - 3'h1)
          begin
            ctx_reg.sp <= ctx_reg.sp - 16'(ips_pkg::FRAME_LEN);
            ctx_reg.condition_code_register[ips_pkg::CCR_I_BIT] <= 1'b1;
            state_reg  <= S_VECT;
            step_reg   <= 3'h0;
          end
          else
          begin
            step_reg <= step_reg + 3'h1;
          end
        end
        S_VECT:
        begin
          // Read high then low byte; data lands a cycle later
          if (step_reg < ips_pkg::VEC_LEN && !testVec_reg)
          begin
            memReq.re   <= 1'b1;                         // [R05]
            memReq.addr <= vec_reg + 16'(step_reg);
          end
          if (step_reg == 3'h1)
          begin
            pcNew_reg[15:8] <= testVec_reg ? ips_pkg::TEST_VEC_HI
                                           : memRdata;   // [R11]
          end
          if (step_reg == ips_pkg::VEC_LEN)
          begin
            ctx_reg.pc <= {pcNew_reg[15:8],
                           testVec_reg ? ips_pkg::TEST_VEC_LO
                                       : memRdata};      // [R11]
            ctxLoad    <= 1'b1;
            state_reg  <= S_IDLE;
            step_reg   <= 3'h0;
          end
          else
          begin
            step_reg <= step_reg + 3'h1;
          end
        end
        S_PULL:
        begin
          // Unstack upward from SP+1: CONDITION_CODE_REGISTER, A, X, PCL, PCH
          if (step_reg < ips_pkg::FRAME_LEN)
          begin
            memReq.re   <= 1'b1;                         // [R15]
            memReq.addr <= ctx_reg.sp + 16'(step_reg) + 16'h0001;
          end
          case (step_reg)
            3'h1:    ctx_reg.condition_code_register     <= memRdata;        // [R15]
            3'h2:    ctx_reg.acc     <= memRdata;
            3'h3:    ctx_reg.idxLo   <= memRdata;
            3'h4:    ctx_reg.pc[7:0] <= memRdata;
            3'h5:    ctx_reg.pc[15:8] <= memRdata;
            default: ctx_reg.pc      <= ctx_reg.pc;
          endcase
          if (step_reg == ips_pkg::FRAME_LEN)
          begin
            ctx_reg.sp <= ctx_reg.sp + 16'(ips_pkg::FRAME_LEN);
            ctxLoad    <= 1'b1;
            evtSet[ips_pkg::EVT_RTI] <= 1'b1;
            state_reg  <= S_FETCH;
            step_reg   <= 3'h0;
          end
          else
          begin
            step_reg <= step_reg + 3'h1;
          end
        end
        S_FETCH:
        begin
          // A request still pending is taken before the next opcode
          if (step_reg == 3'h0 && hwReq)
          begin
            ctx_reg.pc  <= ctx_reg.pc - 16'h0001;        // [R12] [R02]
            vec_reg     <= vecOf(win);
            testVec_reg <= (win == 3'(ips_pkg::SRC_TEST));
            evtSet[ips_pkg::EVT_HW] <= 1'b1;
            state_reg   <= S_PUSH;
          end
          else
          begin
            if (step_reg < 3'h2)
            begin
              memReq.re   <= 1'b1;                       // [R15]
              memReq.addr <= ctx_reg.pc + 16'(step_reg);
            end
            if (step_reg == 3'h1)
            begin
              opcodeOut <= memRdata;
            end
            if (step_reg == 3'h2)
            begin
              operandOut <= memRdata;
              fetchDone  <= 1'b1;
              state_reg  <= S_IDLE;
              step_reg   <= 3'h0;
            end
            else
            begin
              step_reg <= step_reg + 3'h1;
            end
          end
        end
        default:
        begin
          state_reg <= S_IDLE;
          step_reg  <= 3'h0;
        end
      endcase
    end
  end

  // AHB-Lite slave: zero wait, read data prepared at address phase
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
      dpWr_reg   <= 1'b0;
      dpAddr_reg <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hsel && hready && htrans[1])
      begin
        dpWr_reg   <= hwrite;
        dpAddr_reg <= haddr[7:0];
        // Unmapped words read zero and writes there do nothing
        hrdata     <= hwrite ? 32'h0000_0000 : rdMux(haddr[7:0]);
      end
      else if (hready)
      begin
        dpWr_reg <= 1'b0;
      end
    end
  end

  // Event status is write-one-to-clear; a new event beats the clear.
  // Pending registers take no writes at all. [R14]
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      evtSts_reg  <= ips_pkg::RST_EVT;
      evtMask_reg <= ips_pkg::RST_EVT;
    end
    else
    begin
      if (dpWr_reg && dpAddr_reg == ips_pkg::OFS_EVT_STS)
      begin
        evtSts_reg <= (evtSts_reg & ~hwdata[2:0]) | evtSet;
      end
      else
      begin
        evtSts_reg <= evtSts_reg | evtSet;
      end
      if (dpWr_reg && dpAddr_reg == ips_pkg::OFS_EVT_MASK)
      begin
        evtMask_reg <= hwdata[2:0];
      end
    end
  end

  // Level interrupt while any unmasked event is set
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(evtSts_reg & evtMask_reg);
    end
  end

endmodule

/* verif/ips_interrupt_priority_status_asserts.sv */
// Checker for the interrupt priority block, sees top ports only.
// Assumes one clock and the memory answering reads a cycle later.
`timescale 1ns/1ns
module ips_interrupt_priority_status_asserts #(
  parameter int NUM_SRC = 7
) (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [NUM_SRC-1:0] srcFlag,
  input wire logic [NUM_SRC-1:0] srcEn,
  input wire logic               instrEnd,
  input wire logic               trapExec,
  input wire logic               rtiExec,
  input wire ips_pkg::ips_ctx_t  ctxIn,
  input wire ips_pkg::ips_ctx_t  ctxOut,
  input wire logic               ctxLoad,
  input wire logic               busy,
  input wire logic               fetchDone,
  input wire ips_pkg::ips_mem_t  memReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Vector per source index, highest priority first
  localparam logic [15:0] VTAB [7] = '{16'hFFFA, 16'hFFF6, 16'hFFF4,
    16'hFFF2, 16'hFFEC, 16'hFFE0, 16'hFFDE};
  logic [NUM_SRC-1:0] req;      // Enabled requests
  logic               take;     // Boundary accepted while idle
  logic               hwTake;   // Unmasked hardware entry accepted
  logic               isEntry;  // Last take was an entry
  logic [15:0]        tSp;      // Stack pointer at take
  logic [15:0]        tPc;      // Program counter at take
  logic [15:0]        tVec;     // Expected vector at take
  // Lowest set index wins; loop runs downward so it ends on it
  function automatic logic [15:0] expVec(input logic [NUM_SRC-1:0] r);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = NUM_SRC - 1; i >= 0; i--)
      if (r[i])
        v = VTAB[i];
    return v;
  endfunction
  assign req = srcFlag & srcEn;
  assign take = instrEnd && !busy;
  assign hwTake = take && !trapExec && !rtiExec && !ctxIn.condition_code_register[3]
                  && (req != '0);
  // Context captured at each take; core may change ctxIn afterwards
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      isEntry <= 1'b0;
      tSp <= 16'h0000;
      tPc <= 16'h0000;
      tVec <= 16'h0000;
    end
    else if (take)
    begin
      isEntry <= !rtiExec;
      tSp <= ctxIn.sp;
      tPc <= ctxIn.pc;
      tVec <= expVec(req);
    end
  end
  property p_trap_enter;
    take && trapExec |-> ##[7:10] ctxLoad;
  endproperty
  a_trap_enter: assert property (p_trap_enter)
    else $error("trap entry did not load a context");
  property p_mask;
    take && !trapExec && !rtiExec && ctxIn.condition_code_register[3] |=> !busy [*3];
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked request was taken");
  property p_trap_pc;
    take && trapExec |-> ##[1:2] (memReq.we && memReq.addr == tSp
      && memReq.wdata == tPc[15:8]);
  endproperty
  a_trap_pc: assert property (p_trap_pc)
    else $error("trap stacked wrong high byte");
  property p_hw_pc;
    hwTake |-> ##[1:2] (memReq.we && memReq.addr == tSp
      && memReq.wdata == tPc[15:8] - {7'h00, tPc[7:0] == 8'h00});
  endproperty
  a_hw_pc: assert property (p_hw_pc)
    else $error("hardware entry stacked wrong high byte");
  property p_frame;
    $rose(memReq.we) |-> memReq.we [*5] ##1 !memReq.we;
  endproperty
  a_frame: assert property (p_frame)
    else $error("stack frame is not five bytes");
  property p_prio;
    hwTake && $stable(req) && expVec(req) != ips_pkg::VEC_TEST
      |-> ##[5:8] (memReq.re && memReq.addr == tVec);
  endproperty
  a_prio: assert property (p_prio)
    else $error("vector of wrong source fetched");
  property p_entry_ctx;
    ctxLoad && isEntry |-> ctxOut.condition_code_register[3] && ctxOut.sp == tSp - 16'h0005;
  endproperty
  a_entry_ctx: assert property (p_entry_ctx)
    else $error("entry left mask clear or stack wrong");
  property p_rti_rd;
    take && rtiExec && !trapExec
      |-> ##[1:2] (memReq.re && memReq.addr == tSp + 16'h0001);
  endproperty
  a_rti_rd: assert property (p_rti_rd)
    else $error("return did not pull from stack top");
  property p_fetch;
    take && rtiExec && !trapExec && req == '0 |-> ##[8:11] fetchDone;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("return fetch did not complete");
  c_trap: cover property (take && trapExec);
  c_hw: cover property (hwTake);
  c_fetch: cover property (fetchDone);
endmodule
bind ips_interrupt_priority_status ips_interrupt_priority_status_asserts
  #(.NUM_SRC(NUM_SRC)) i_ips_interrupt_priority_status_asserts (.clk,
  .rstn, .srcFlag, .srcEn, .instrEnd, .trapExec, .rtiExec, .ctxIn,
  .ctxOut, .ctxLoad, .busy, .fetchDone, .memReq);

/* verif/ips_mem_model.sv */
// Byte memory on the far side of the block's memory port.
// Unwritten bytes read a pattern of their address.
`timescale 1ns/1ns
module ips_mem_model (
  input  wire logic              clk,
  input  wire ips_pkg::ips_mem_t memReq,
  output logic [7:0]             memRdata
);
  logic [7:0] mem [int];  // Bytes written so far
  // Fill pattern, so vectors differ per address
  function automatic logic [7:0] fill(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // Writes land at the edge that ends the request cycle
  always @(posedge clk)
  begin
    if (memReq.we)
      mem[memReq.addr] = memReq.wdata;
  end
  // Read data stands in the request's own cycle, the block takes it
  // at the next edge; with no read the byte is inverted
  always @(memReq)
  begin
    memRdata = mem.exists(memReq.addr) ? mem[memReq.addr]
                                       : fill(memReq.addr);
    if (!memReq.re)
      memRdata = ~memRdata;
  end
endmodule

/* verif/ips_interrupt_priority_status_tb.sv */
// Testbench for the interrupt priority block.
// Assumes the memory model answers reads one cycle later.
`timescale 1ns/1ns
module ips_interrupt_priority_status_tb;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [6:0]        srcFlag = 7'h00;
  logic [6:0]        srcEn = 7'h00;
  logic              instrEnd = 1'b0;
  logic              trapExec = 1'b0;
  logic              rtiExec = 1'b0;
  ips_pkg::ips_ctx_t ctxIn = '0;
  ips_pkg::ips_ctx_t ctxOut;
  ips_pkg::ips_mem_t memReq;
  logic              ctxLoad, busy, fetchDone, irq, hreadyout, hresp;
  logic [7:0]        opcodeOut, operandOut, memRdata;
  logic              hsel = 1'b1;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       hrdata;
  int                error_cnt = 0;
  int                checks = 0;
  // Vector per source, highest priority first
  logic [15:0] vtab [7] = '{ips_pkg::VEC_EXT, ips_pkg::VEC_CH0,
    ips_pkg::VEC_CH1, ips_pkg::VEC_OVF, ips_pkg::VEC_TEST,
    ips_pkg::VEC_KEY, ips_pkg::VEC_CONV};
  always #20 clk = ~clk;
  ips_interrupt_priority_status #(.NUM_SRC(7)) i_ips_interrupt_priority_status
    (.clk, .rstn, .srcFlag, .srcEn, .instrEnd, .trapExec, .rtiExec,
    .ctxIn, .ctxOut, .ctxLoad, .busy, .opcodeOut, .operandOut, .fetchDone,
    .memReq, .memRdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq);
  ips_mem_model i_ips_mem_model (.clk, .memReq, .memRdata);
  // Same fill as the memory model, kept apart on purpose
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; entered and left right after an edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask
  // Boundary pulse once the block is idle; waits are bounded
  task automatic step(input logic tr, input logic rt,
                      input ips_pkg::ips_ctx_t c);
    repeat (50) if (busy !== 1'b0) @(posedge clk);
    instrEnd <= 1'b1;
    trapExec <= tr;
    rtiExec <= rt;
    ctxIn <= c;
    @(posedge clk);
    instrEnd <= 1'b0;
    trapExec <= 1'b0;
    rtiExec <= 1'b0;
  endtask
  task automatic wait_load;
    repeat (20) if (ctxLoad !== 1'b1) @(posedge clk);
    chk(ctxLoad, 1'b1);
  endtask
  task automatic t_reset;
    wait_load();
    chk(ctxOut.pc, {pat(16'hFFFE), pat(16'hFFFF)});
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h10, 32'h0);
    $display("reset test done");
  endtask
  // Trap while masked, then return and fetch
  task automatic t_trap;
    ips_pkg::ips_ctx_t c;
    logic [7:0] f [5];
    c = '{pc:16'h1234, sp:16'h00F0, condition_code_register:8'h08, acc:8'hA5, idxLo:8'h3C};
    f = '{8'h12, 8'h34, 8'h3C, 8'hA5, 8'h08};
    step(1'b1, 1'b0, c);
    wait_load();
    chk(ctxOut.pc, {pat(16'hFFFC), pat(16'hFFFD)});
    for (int i = 0; i < 5; i++)
      chk(i_ips_mem_model.mem[240 - i], f[i]);
    chk({ctxOut.sp, 7'h0, ctxOut.condition_code_register[3]}, 24'h00EB01);
    c.sp = 16'h00EB;
    step(1'b0, 1'b1, c);
    wait_load();
    chk({ctxOut.pc, ctxOut.acc, ctxOut.idxLo}, 32'h1234A53C);
    chk({ctxOut.sp, ctxOut.condition_code_register}, 24'h00F008);
    repeat (10) if (fetchDone !== 1'b1) @(posedge clk);
    chk({opcodeOut, operandOut}, {pat(16'h1234), pat(16'h1235)});
    $display("trap test done");
  endtask
  // Pending source held off by the global mask
  task automatic t_mask;
    ips_pkg::ips_ctx_t c;
    logic [31:0] d;
    int n;
    c = '{pc:16'h4000, sp:16'h0080, condition_code_register:8'h08, acc:8'h00, idxLo:8'h00};
    n = 0;
    srcFlag <= 7'h01;
    srcEn <= 7'h7F;
    step(1'b0, 1'b0, c);
    repeat (12)
    begin
      @(posedge clk);
      if (ctxLoad === 1'b1)
        n++;
    end
    chk(n, 0);
    rd_chk(8'h00, 32'h04);
    ahb(1'b1, 8'h00, 32'hFF, d);
    rd_chk(8'h00, 32'h04);
    $display("mask test done");
  endtask
  // Each source as the highest of a pending group
  task automatic t_prio;
    ips_pkg::ips_ctx_t c;
    logic [6:0] f;
    logic [15:0] e;
    for (int i = 0; i < 7; i++)
    begin
      f = 7'h7F << i;
      c = '{pc:16'h2000 + i[15:0], sp:16'h0080, condition_code_register:8'h00, acc:8'h11,
            idxLo:8'h22};
      e = c.pc - 16'h0001;
      srcFlag <= f;
      repeat (2) @(posedge clk);
      rd_chk(8'h00, {f[3:1], 1'b0, f[0], 2'b0});
      rd_chk(8'h04, {f[5], 5'h0, f[4], 1'b0});
      step(1'b0, 1'b0, c);
      wait_load();
      chk(ctxOut.pc, i == 4 ? 16'h0083
          : {pat(vtab[i]), pat(vtab[i] + 16'h0001)});
      chk(i_ips_mem_model.mem[128], e[15:8]);
      chk(i_ips_mem_model.mem[127], e[7:0]);
    end
    // Return with the converter still pending re-enters at once
    c.sp = 16'h007B;
    step(1'b0, 1'b1, c);
    wait_load();
    @(posedge clk);
    wait_load();
    chk(ctxOut.pc, {pat(16'hFFDE), pat(16'hFFDF)});
    chk(i_ips_mem_model.mem[127], 8'h04);
    srcFlag <= 7'h00;
    $display("priority test done");
  endtask
  // Event status, mask and the interrupt line
  task automatic t_evt;
    logic [31:0] d;
    rd_chk(8'h08, 32'h7);
    chk(irq, 1'b0);
    ahb(1'b1, 8'h0C, 32'h1, d);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rd_chk(8'h0C, 32'h1);
    ahb(1'b1, 8'h08, 32'h1, d);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rd_chk(8'h08, 32'h6);
    $display("event test done");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 200 cycles the tests take
  initial
  begin
    #(40 * 5000);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_trap();
    t_mask();
    t_prio();
    t_evt();
    tally_and_finish();
  end
endmodule
